/* File: hw/boot_wake_regs.svh */
// Register offsets, field positions and timing constants for boot strap and wake control
`ifndef BOOT_WAKE_REGS_SVH
`define BOOT_WAKE_REGS_SVH
`define SFR_DEVICE_IDENTITY 8'hC2
`define SFR_POWER_CONTROL 8'h87
`define POWER_CONTROL_REG_IDLE_BIT 0
`define POWER_CONTROL_REG_PDOWN_BIT 1
`define POWER_CONTROL_REG_IRQ0_WAKE_BIT 5
`define POWER_CONTROL_REG_RESET 8'h00
`define PLL_MULTIPLIER 384
`define PLL_REF_HZ 32768
`define PLL_LOCK_CYCLES 16'h0040
`endif

/* File: hw/boot_wake_pkg.sv */
// Types shared by the boot strap and wake control block
package boot_wake_pkg;
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_IDLE = 2'b01,
      PWR_DOWN = 2'b11,
      PWR_RELOCK = 2'b10
   } power_state_t;
   typedef enum logic {
      BOOT_USER = 1'b0,
      BOOT_DOWNLOAD = 1'b1
   } boot_mode_t;
endpackage : boot_wake_pkg

/* File: hw/strap_capture.sv */
// Samples the boot strap pin once as reset is released
`timescale 1ns/10ps
`default_nettype none
module strap_capture (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Strap pin, already synchronised
   input wire logic i_strap_sync,
   // Result
   output boot_wake_pkg::boot_mode_t o_boot_mode,
   output logic o_captured
);
   import boot_wake_pkg::*;
   boot_mode_t mode_ff;
   boot_mode_t nxt_mode;
   logic done_ff;
   logic nxt_done;
   always_comb begin
      nxt_mode = mode_ff;
      nxt_done = done_ff;
      if (!done_ff) begin
         nxt_mode = i_strap_sync ? BOOT_USER : BOOT_DOWNLOAD;
         nxt_done = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         mode_ff <= BOOT_USER;
         done_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         done_ff <= nxt_done;
      end
   end
   assign o_boot_mode = mode_ff;
   assign o_captured = done_ff;
   a_mode_held: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      done_ff |=> $stable(mode_ff)) else $error("boot mode changed");
endmodule : strap_capture
`default_nettype wire

/* File: hw/pll_lock.sv */
// Lock timer for the core PLL; gates the core clock enable
`timescale 1ns/10ps
`default_nettype none
`include "boot_wake_regs.svh"
module pll_lock #(
   parameter logic [15:0] LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Control
   input wire logic i_pll_run,
   // Status
   output logic o_locked
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   always_comb begin
      // Stopped PLL loses lock; restart counts from zero
      if (!i_pll_run) begin
         nxt_cnt = 16'h0000;
      end else if (cnt_ff != LOCK_CYCLES) begin
         nxt_cnt = cnt_ff + 16'h0001;
      end else begin
         nxt_cnt = cnt_ff;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   assign o_locked = (cnt_ff == LOCK_CYCLES);
endmodule : pll_lock
`default_nettype wire

/* File: hw/boot_strap_and_wake_control.sv */
// Boot strap capture, power-down and wake control, identity register
`timescale 1ns/10ps
`default_nettype none
`include "boot_wake_regs.svh"
module boot_strap_and_wake_control #(
   parameter logic [3:0] VARIANT_CODE = 4'hA, // Arbitrary value
   parameter logic [3:0] REVISION_CODE = 4'h1, // Arbitrary value
   parameter logic [15:0] LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Special-function register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // Core handshake
   input wire logic i_core_strobe_drive,
   input wire logic i_core_ale,
   input wire logic i_reti,
   output logic o_core_clk_en,
   output logic o_irq0_vector_req,
   output logic o_resume_pending,
   output logic o_pll_run,
   output boot_wake_pkg::boot_mode_t o_boot_mode,
   output boot_wake_pkg::power_state_t o_power_state,
   // Pins
   input wire logic i_program_store_strobe,
   output logic o_program_store_strobe,
   output logic o_program_store_strobe_oe_n,
   output logic o_ale,
   input wire logic i_external_irq_zero_n
);
   import boot_wake_pkg::*;

   // Two-stage synchronisers for pins
   logic strobe_s1_ff;
   logic strobe_s2_ff;
   logic irq_s1_ff;
   logic irq_s2_ff;
   // Strap stages run through reset so the pin level is settled at release
   always_ff @(posedge i_clk) begin
      strobe_s1_ff <= i_program_store_strobe;
      strobe_s2_ff <= strobe_s1_ff;
   end
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         irq_s1_ff <= 1'b1;
         irq_s2_ff <= 1'b1;
      end else begin
         irq_s1_ff <= i_external_irq_zero_n;
         irq_s2_ff <= irq_s1_ff;
      end
   end

   boot_mode_t boot_mode;
   logic strap_done;
   strap_capture u_strap (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_strap_sync(strobe_s2_ff),
      .o_boot_mode(boot_mode),
      .o_captured(strap_done)
   );

   // Power control register and state
   logic [7:0] power_control_reg_ff;
   logic [7:0] nxt_power_control_reg;
   power_state_t state_ff;
   power_state_t nxt_state;
   logic vec_ff;
   logic nxt_vec;
   logic resume_ff;
   logic nxt_resume;
   logic pll_run_ff;
   logic nxt_pll_run;
   logic locked;
   logic irq_low;
   logic power_control_reg_wr;

   assign irq_low = !irq_s2_ff;
   assign power_control_reg_wr = i_sfr_wr && (i_sfr_addr == `SFR_POWER_CONTROL);

   pll_lock #(
      .LOCK_CYCLES(LOCK_CYCLES)
   ) u_pll (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pll_run(pll_run_ff),
      .o_locked(locked)
   );

   always_comb begin
      nxt_power_control_reg = power_control_reg_ff;
      nxt_state = state_ff;
      nxt_vec = 1'b0;
      nxt_resume = resume_ff;
      nxt_pll_run = pll_run_ff;
      if (power_control_reg_wr) begin
         nxt_power_control_reg = i_sfr_wdata;
      end
      case (state_ff)
         PWR_RUN: begin
            // Strap must be settled before user code may sleep
            if (power_control_reg_wr && strap_done && i_sfr_wdata[`POWER_CONTROL_REG_PDOWN_BIT]) begin
               nxt_state = PWR_DOWN;
               nxt_pll_run = 1'b0;
            end else if (power_control_reg_wr && strap_done && i_sfr_wdata[`POWER_CONTROL_REG_IDLE_BIT]) begin
               nxt_state = PWR_IDLE;
            end
            if (i_reti && resume_ff) begin
               nxt_resume = 1'b0;
            end
         end
         PWR_IDLE: begin
            if (irq_low && power_control_reg_ff[`POWER_CONTROL_REG_IRQ0_WAKE_BIT]) begin
               nxt_state = PWR_RUN;
               nxt_vec = 1'b1;
               nxt_resume = 1'b1;
               nxt_power_control_reg[`POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
            end
         end
         PWR_DOWN: begin
            // Wake enable is read from the register; a write made in this state is seen from the next cycle
            if (irq_low && power_control_reg_ff[`POWER_CONTROL_REG_IRQ0_WAKE_BIT]) begin
               nxt_state = PWR_RELOCK;
               nxt_pll_run = 1'b1;
            end
         end
         PWR_RELOCK: begin
            if (locked) begin
               nxt_state = PWR_RUN;
               nxt_vec = 1'b1;
               nxt_resume = 1'b1;
               nxt_power_control_reg[`POWER_CONTROL_REG_PDOWN_BIT] = 1'b0;
            end
         end
         default: begin
            nxt_state = PWR_RUN;
            nxt_pll_run = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         power_control_reg_ff <= `POWER_CONTROL_REG_RESET;
         state_ff <= PWR_RELOCK;
         vec_ff <= 1'b0;
         resume_ff <= 1'b0;
         pll_run_ff <= 1'b1;
      end else begin
         power_control_reg_ff <= nxt_power_control_reg;
         state_ff <= nxt_state;
         vec_ff <= nxt_vec;
         resume_ff <= nxt_resume;
         pll_run_ff <= nxt_pll_run;
      end
   end

   // Register read, pins and clock enable, all from flops
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic clk_en_ff;
   logic nxt_clk_en;
   logic strobe_ff;
   logic nxt_strobe;
   logic strobe_oe_n_ff;
   logic nxt_strobe_oe_n;
   logic ale_ff;
   logic nxt_ale;
   always_comb begin
      case (i_sfr_addr)
         `SFR_DEVICE_IDENTITY: nxt_rdata = {VARIANT_CODE, REVISION_CODE};
         `SFR_POWER_CONTROL: nxt_rdata = power_control_reg_ff;
         default: nxt_rdata = 8'h00;
      endcase
      // Clock returns on the same edge as the wake vector
      nxt_clk_en = (nxt_state == PWR_RUN);
      nxt_strobe_oe_n = 1'b0;
      nxt_strobe = i_core_strobe_drive;
      nxt_ale = i_core_ale;
      if (!strap_done) begin
         nxt_strobe_oe_n = 1'b1;
         nxt_strobe = 1'b1;
         nxt_ale = 1'b0;
      end else if (nxt_state == PWR_DOWN || nxt_state == PWR_RELOCK) begin
         nxt_strobe = 1'b0;
         nxt_ale = 1'b0;
      end else if (nxt_state == PWR_IDLE) begin
         nxt_strobe = 1'b1;
         nxt_ale = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rdata_ff <= 8'h00;
         clk_en_ff <= 1'b0;
         strobe_ff <= 1'b1;
         strobe_oe_n_ff <= 1'b1;
         ale_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         clk_en_ff <= nxt_clk_en;
         strobe_ff <= nxt_strobe;
         strobe_oe_n_ff <= nxt_strobe_oe_n;
         ale_ff <= nxt_ale;
      end
   end

   assign o_sfr_rdata = rdata_ff;
   assign o_core_clk_en = clk_en_ff;
   assign o_irq0_vector_req = vec_ff;
   assign o_resume_pending = resume_ff;
   assign o_pll_run = pll_run_ff;
   assign o_boot_mode = boot_mode;
   assign o_power_state = state_ff;
   assign o_program_store_strobe = strobe_ff;
   assign o_program_store_strobe_oe_n = strobe_oe_n_ff;
   assign o_ale = ale_ff;

   a_wake_needs_en: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == PWR_DOWN && !power_control_reg_ff[`POWER_CONTROL_REG_IRQ0_WAKE_BIT]) |=> state_ff == PWR_DOWN)
      else $error("woke without enable");
   a_wake_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == PWR_DOWN && irq_low && power_control_reg_ff[`POWER_CONTROL_REG_IRQ0_WAKE_BIT])
      |=> state_ff == PWR_RELOCK && pll_run_ff) else $error("wake missed");
   a_vector_after: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == PWR_RELOCK && locked) |=> vec_ff && resume_ff && state_ff == PWR_RUN)
      else $error("no vector after relock");
   a_id_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_sfr_addr == `SFR_DEVICE_IDENTITY |=> o_sfr_rdata == {VARIANT_CODE, REVISION_CODE})
      else $error("identity wrong");
   a_pd_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == PWR_RUN && power_control_reg_wr && strap_done && i_sfr_wdata[`POWER_CONTROL_REG_PDOWN_BIT])
      |=> state_ff == PWR_DOWN && !pll_run_ff) else $error("no power-down");
   a_pd_pins_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state_ff == PWR_DOWN |-> !o_program_store_strobe && !o_ale && !o_core_clk_en)
      else $error("pins not low in power-down");
   a_strap_input: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !strap_done |=> o_program_store_strobe_oe_n) else $error("strobe driven at strap");
   a_strobe_output: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      strap_done ##1 strap_done |=> !o_program_store_strobe_oe_n)
      else $error("strobe not driven");
   a_boot_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !strap_done |=> o_boot_mode == ($past(strobe_s2_ff) ? BOOT_USER : BOOT_DOWNLOAD))
      else $error("boot mode wrong");
   c_download: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      strap_done && boot_mode == BOOT_DOWNLOAD);
   c_pd_wake: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      state_ff == PWR_RELOCK ##1 vec_ff);
   c_idle: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_ff == PWR_IDLE);
endmodule : boot_strap_and_wake_control
`default_nettype wire

/* File: verif/board_partner.sv */
// Board model: strap jumper with pull-up and irq zero source
`timescale 1ns/10ps
`default_nettype none
module board_partner (
   // Device side of the strobe pin
   input wire logic i_oe_n,
   input wire logic i_drive,
   // Board controls
   input wire logic i_jumper,
   input wire logic i_irq_low,
   // Resolved wires
   output logic o_strobe_pin,
   output logic o_irq_zero_n
);
   // Driver beats the 1k jumper; when undriven, only the jumper pulls low
   assign o_strobe_pin = !i_oe_n ? i_drive : !i_jumper;
   // Irq line idles high through its pull-up
   assign o_irq_zero_n = !i_irq_low;
endmodule : board_partner
`default_nettype wire

/* File: verif/tb_boot_strap_and_wake_control.sv */
// Self-checking bench for boot strap and wake control
`timescale 1ns/10ps
`default_nettype none
module tb_boot_strap_and_wake_control;
   import boot_wake_pkg::*;
   // Arbitrary identity values
   localparam logic [3:0] VAR_CODE = 4'h6;
   localparam logic [3:0] REV_CODE = 4'h3;
   logic i_clk, i_reset_n, i_sfr_wr, i_core_strobe_drive, i_core_ale, i_reti;
   logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
   logic o_core_clk_en, o_irq0_vector_req, o_resume_pending, o_pll_run;
   logic o_program_store_strobe, o_program_store_strobe_oe_n, o_ale;
   logic jumper, irq_low;
   wire logic strobe_pin, irq_zero_n;
   boot_mode_t o_boot_mode;
   power_state_t o_power_state;
   int error_cnt, n_tests, cyc;

   // Short lock count keeps the run brief
   boot_strap_and_wake_control #(.VARIANT_CODE(VAR_CODE), .REVISION_CODE(REV_CODE),
      .LOCK_CYCLES(16'h0004)) u_boot_strap_and_wake_control (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
      .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
      .i_core_strobe_drive(i_core_strobe_drive), .i_core_ale(i_core_ale), .i_reti(i_reti),
      .o_core_clk_en(o_core_clk_en), .o_irq0_vector_req(o_irq0_vector_req),
      .o_resume_pending(o_resume_pending), .o_pll_run(o_pll_run),
      .o_boot_mode(o_boot_mode), .o_power_state(o_power_state),
      .i_program_store_strobe(strobe_pin), .o_program_store_strobe(o_program_store_strobe),
      .o_program_store_strobe_oe_n(o_program_store_strobe_oe_n), .o_ale(o_ale),
      .i_external_irq_zero_n(irq_zero_n));

   board_partner u_board_partner (.i_oe_n(o_program_store_strobe_oe_n),
      .i_drive(o_program_store_strobe), .i_jumper(jumper), .i_irq_low(irq_low),
      .o_strobe_pin(strobe_pin), .o_irq_zero_n(irq_zero_n));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   // Hang guard, well above the hundred or so cycles needed
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : step

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_sfr_addr <= a;
      i_sfr_wdata <= d;
      i_sfr_wr <= 1'b1;
      @(posedge i_clk);
      i_sfr_wr <= 1'b0;
   endtask : sfr_wr

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_sfr_addr <= a;
      step(1);
      d = o_sfr_rdata;
   endtask : sfr_rd

   task automatic do_reset(input logic j);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      jumper <= j;
      repeat (12) @(posedge i_clk);
      i_reset_n <= 1'b1;
   endtask : do_reset

   task automatic wait_run;
      for (int k = 0; k < 60; k++) begin
         step(1);
         if (o_core_clk_en === 1'b1) break;
      end
      chk({7'h00, o_core_clk_en}, 8'h01);
   endtask : wait_run

   initial begin
      logic [7:0] rd;
      {i_reset_n, i_sfr_wr, i_reti, jumper, irq_low} = 5'b00000;
      {i_sfr_addr, i_sfr_wdata} = 16'h0000;
      i_core_strobe_drive = 1'b1;
      i_core_ale = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      cyc = 0;
      do_reset(1'b0);
      wait_run();
      chk({7'h00, o_boot_mode}, {7'h00, BOOT_USER});
      sfr_rd(8'hC2, rd);
      chk(rd, {VAR_CODE, REV_CODE});
      sfr_wr(8'hC2, 8'h00);
      sfr_rd(8'hC2, rd);
      chk(rd, {VAR_CODE, REV_CODE});
      sfr_rd(8'h10, rd);
      chk(rd, 8'h00);
      @(posedge i_clk);
      i_core_strobe_drive <= 1'b0;
      step(3);
      chk({6'h00, o_program_store_strobe_oe_n, strobe_pin}, 8'h00);
      @(posedge i_clk);
      jumper <= 1'b1;
      step(5);
      chk({7'h00, o_boot_mode}, {7'h00, BOOT_USER});
      $display("test 1 strap user and identity done");
      sfr_wr(8'h87, 8'h02);
      step(1);
      chk({6'h00, o_power_state}, {6'h00, PWR_DOWN});
      chk({4'h0, o_pll_run, o_core_clk_en, o_program_store_strobe, o_ale}, 8'h00);
      @(posedge i_clk);
      irq_low <= 1'b1;
      step(12);
      chk({6'h00, o_power_state}, {6'h00, PWR_DOWN});
      irq_low <= 1'b0;
      $display("test 2 sleep without wake enable done");
      do_reset(1'b1);
      wait_run();
      chk({7'h00, o_boot_mode}, {7'h00, BOOT_DOWNLOAD});
      @(posedge i_clk);
      jumper <= 1'b0;
      step(5);
      chk({7'h00, o_boot_mode}, {7'h00, BOOT_DOWNLOAD});
      $display("test 3 strap download done");
      sfr_wr(8'h87, 8'h22);
      step(1);
      chk({6'h00, o_power_state}, {6'h00, PWR_DOWN});
      @(posedge i_clk);
      irq_low <= 1'b1;
      wait_run();
      chk({6'h00, o_irq0_vector_req, o_resume_pending}, 8'h03);
      irq_low <= 1'b0;
      step(1);
      chk({7'h00, o_irq0_vector_req}, 8'h00);
      sfr_rd(8'h87, rd);
      chk(rd, 8'h20);
      @(posedge i_clk);
      i_reti <= 1'b1;
      @(posedge i_clk);
      i_reti <= 1'b0;
      step(1);
      chk({7'h00, o_resume_pending}, 8'h00);
      $display("test 4 wake from sleep done");
      sfr_wr(8'h87, 8'h01);
      step(1);
      chk({6'h00, o_power_state}, {6'h00, PWR_IDLE});
      chk({6'h00, o_program_store_strobe, o_ale}, 8'h03);
      $display("test 5 idle done");
      complete_run();
   end
endmodule : tb_boot_strap_and_wake_control
`default_nettype wire
